// [include/cis_pkg.sv]
`default_nettype none
package cis_pkg;

	// irq_control_reg bit positions
	localparam int CTL_GIE   = 7;
	localparam int CTL_PERIPHERAL_IRQ_ENABLE  = 6;
	localparam int CTL_TMR_E = 5;
	localparam int CTL_EXT_E = 4;
	localparam int CTL_PC_E  = 3;
	localparam int CTL_TMR_F = 2;
	localparam int CTL_EXT_F = 1;
	localparam int CTL_PC_F  = 0;

	// values after any reset
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] PIE_RESET = 8'h00;
	localparam logic [7:0] PIR_RESET = 8'h00;

	// implemented peripheral enable/request bits (6, 4, 3, 1)
	localparam logic [7:0] PERIPH_MASK = 8'h5a;

	// service routine entry address
	localparam logic [15:0] VECTOR_ADDR = 16'h0004;

	// clocks per instruction cycle and post-wake hold
	localparam int PHASES_PER_CYCLE = 4;
	localparam logic [1:0] WAKE_HOLD_CYC = 2'h2;

	// latency window in instruction cycles
	localparam int SYNC_LAT_MIN  = 3;
	localparam int SYNC_LAT_MAX  = 4;
	localparam int ASYNC_LAT_MAX = 5;

	typedef enum logic [1:0] {
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} cis_phase_e;

	typedef struct packed {
		logic       ctl_we;
		logic       pie_we;
		logic       pir_we;
		logic [7:0] data;
	} cis_wr_s;

	typedef struct packed {
		logic       timer_ovf;
		logic [7:0] periph;
	} cis_evt_s;

	typedef struct packed {
		logic return_from_interrupt;
		logic asleep;
	} cis_core_s;

	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] pie;
		logic [7:0] pir;
	} cis_regs_s;

	typedef struct packed {
		logic        flush;
		logic        push;
		logic        load_vector;
		logic        pop;
		logic [15:0] vector;
	} cis_cmd_s;

endpackage : cis_pkg
`default_nettype wire

// [rtl/cis_ext_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module cis_ext_edge (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic pin_i,
	input  wire logic rise_sel_i,
	output logic      edge_o
);

	logic       meta_ff;
	logic       sync_ff;
	logic       prev_ff;
	logic [2:0] prime_ff;

	// two-stage synchroniser; meta_ff feeds sync_ff only
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= pin_i;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// no edge until meta, sync and prev all hold real pin values;
	// a pin idling high would otherwise look like a rising edge
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prime_ff <= 3'h0;
		end else begin
			prime_ff <= {prime_ff[1:0], 1'b1};
		end
	end

	always_comb begin
		if (!prime_ff[2]) begin
			edge_o = 1'b0;
		end else if (rise_sel_i) begin
			edge_o = sync_ff & ~prev_ff;
		end else begin
			edge_o = ~sync_ff & prev_ff;
		end
	end

endmodule : cis_ext_edge
`default_nettype wire

// [rtl/cis_core.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// - reset clears every enable, so no vector redirection until firmware.
// - request needs global and own enable; peripheral ones also need peripheral_irq_enable.
// - event flags set regardless of any enable bit.
// - entry flushes, clears global enable, pushes pc, loads 0004h.
// - with global enable clear, flags still set but no redirect.
// - return pops pc and sets global enable again.
// - flag set while disabled is serviced once global enable returns.
// - synchronous events reach the vector in three to four cycles.
// - asynchronous events reach the vector in three to five cycles.
// - latency independent of one- or two-cycle current instruction.
// - pin flag may set in phases four and one; sampled every phase one.
// - on wake, vector if global enable set, else continue after sleep.
// - instruction after sleep always executes before the vector.
// - pin edge is rising when select set, falling when clear.
// - selected pin edge sets pin flag; redirect if both enables set.
// - entry saves only the return pc; nothing else is stacked.
// - pin-change summary is read-only, clears when all flags clear.
// - control layout: gie, peripheral_irq_enable, three enables, three flags to bit 0.
module cis_core #(
	parameter int IOC_W = 4
) (
	input  wire logic               clk_i,
	input  wire logic               nrst_i,
	input  wire cis_pkg::cis_wr_s   wr_i,
	input  wire cis_pkg::cis_evt_s  events_i,
	input  wire logic               ext_pin_i,
	input  wire logic               ext_edge_select_i,
	input  wire logic [IOC_W-1:0]   pin_change_flag_reg_i,
	input  wire cis_pkg::cis_core_s core_i,
	output cis_pkg::cis_regs_s      regs_o,
	output cis_pkg::cis_cmd_s       cmd_o,
	output cis_pkg::cis_phase_e     phase_o,
	output logic                    irq_req_o,
	output logic                    wake_o,
	output logic                    service_active_o
);
	import cis_pkg::*;

	cis_phase_e phase_ff;
	cis_phase_e nxt_phase;

	logic [7:0] ctl_ff;
	logic [7:0] nxt_ctl;
	logic [7:0] pie_ff;
	logic [7:0] nxt_pie;
	logic [7:0] pir_ff;
	logic [7:0] nxt_pir;

	logic       ext_edge;
	logic       ext_pend_ff;
	logic       ext_window;
	logic       ext_set;

	logic       tmr_hit;
	logic       ext_hit;
	logic       pc_hit;
	logic       core_hit;
	logic [7:0] periph_pairs;
	logic       periph_any;
	logic       periph_hit;
	logic       any_hit;
	logic       irq_req;
	logic [2:1] hw_set;

	logic [1:0] post_wake_ff;
	logic [1:0] nxt_post_wake;
	logic       sample_ok;
	logic       sample_ff;
	logic       entry;
	cis_cmd_s   cmd_ff;
	cis_cmd_s   nxt_cmd;
	logic       in_service_ff;

	logic       q1;
	logic       q4;

	// instruction cycle phase sequencer
	always_comb begin
		case (phase_ff)
			PH_Q1: begin
				nxt_phase = PH_Q2;
			end
			PH_Q2: begin
				nxt_phase = PH_Q3;
			end
			PH_Q3: begin
				nxt_phase = PH_Q4;
			end
			PH_Q4: begin
				nxt_phase = PH_Q1;
			end
			default: begin
				nxt_phase = PH_Q1;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			phase_ff <= PH_Q1;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	assign q1 = (phase_ff == PH_Q1);
	assign q4 = (phase_ff == PH_Q4);

	// external pin: synchronise, then pick the selected edge
	cis_ext_edge u_ext_edge (
		.clk_i      (clk_i),
		.nrst_i     (nrst_i),
		.pin_i      (ext_pin_i),
		.rise_sel_i (ext_edge_select_i),
		.edge_o     (ext_edge)
	);

	// pin flag may only be set by an edge in phases four and one
	assign ext_window = q4 | q1;

	// an edge outside the window waits rather than being lost
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ext_pend_ff <= 1'b0;
		end else if (ext_edge && !ext_window) begin
			ext_pend_ff <= 1'b1;
		end else if (ext_window) begin
			ext_pend_ff <= 1'b0;
		end
	end

	assign ext_set = ext_window & (ext_edge | ext_pend_ff);

	// request gating, one term per core source
	always_comb begin
		tmr_hit  = ctl_ff[CTL_TMR_E] & ctl_ff[CTL_TMR_F];
		ext_hit  = ctl_ff[CTL_EXT_E] & ctl_ff[CTL_EXT_F];
		pc_hit   = ctl_ff[CTL_PC_E] & ctl_ff[CTL_PC_F];
		core_hit = tmr_hit | ext_hit | pc_hit;
	end

	// peripheral sources need peripheral_irq_enable on top of their own enable;
	// unimplemented bits are masked again so they can never request
	always_comb begin
		periph_pairs = pie_ff & pir_ff & PERIPH_MASK;
		periph_any   = |periph_pairs;
		periph_hit   = ctl_ff[CTL_PERIPHERAL_IRQ_ENABLE] & periph_any;
	end

	// global enable gates everything last
	always_comb begin
		any_hit = core_hit | periph_hit;
		irq_req = ctl_ff[CTL_GIE] & any_hit;
	end

	// hardware sets gathered apart from the software write,
	// so that the set is applied after the write and wins
	always_comb begin
		hw_set = 2'h0;
		if (events_i.timer_ovf) begin
			hw_set[CTL_TMR_F] = 1'b1;
		end
		if (ext_set) begin
			hw_set[CTL_EXT_F] = 1'b1;
		end
	end

	// software write, hardware set; a set in the same cycle wins
	always_comb begin
		nxt_ctl = ctl_ff;
		if (wr_i.ctl_we) begin
			nxt_ctl[CTL_GIE:CTL_EXT_F] = wr_i.data[CTL_GIE:CTL_EXT_F];
		end
		if (entry) begin
			nxt_ctl[CTL_GIE] = 1'b0;
		end
		if (core_i.return_from_interrupt) begin
			nxt_ctl[CTL_GIE] = 1'b1;
		end
		nxt_ctl[CTL_TMR_F] = nxt_ctl[CTL_TMR_F] | hw_set[CTL_TMR_F];
		nxt_ctl[CTL_EXT_F] = nxt_ctl[CTL_EXT_F] | hw_set[CTL_EXT_F];
		// summary bit ignores writes, follows the pin-change flags
		nxt_ctl[CTL_PC_F] = |pin_change_flag_reg_i;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctl_ff <= CTL_RESET;
		end else begin
			ctl_ff <= nxt_ctl;
		end
	end

	// peripheral enables
	always_comb begin
		nxt_pie = pie_ff;
		if (wr_i.pie_we) begin
			nxt_pie = wr_i.data & PERIPH_MASK;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pie_ff <= PIE_RESET;
		end else begin
			pie_ff <= nxt_pie;
		end
	end

	// peripheral flags set whatever the enables say
	always_comb begin
		nxt_pir = pir_ff;
		if (wr_i.pir_we) begin
			nxt_pir = wr_i.data;
		end
		nxt_pir = (nxt_pir | events_i.periph) & PERIPH_MASK;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pir_ff <= PIR_RESET;
		end else begin
			pir_ff <= nxt_pir;
		end
	end

	// wake needs enables only; global enable picks vector or fall-through
	assign wake_o = core_i.asleep & any_hit;

	// hold off entry until the instruction after sleep has run;
	// counted in cycle boundaries, so it cannot end mid-instruction
	always_comb begin
		nxt_post_wake = post_wake_ff;
		if (core_i.asleep) begin
			nxt_post_wake = WAKE_HOLD_CYC;
		end else if (q4 && post_wake_ff != 2'h0) begin
			nxt_post_wake = post_wake_ff - 2'h1;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			post_wake_ff <= 2'h0;
		end else begin
			post_wake_ff <= nxt_post_wake;
		end
	end

	// phase-one sample condition; sleeping or still holding blocks it
	always_comb begin
		sample_ok = irq_req;
		if (core_i.asleep) begin
			sample_ok = 1'b0;
		end
		if (post_wake_ff != 2'h0) begin
			sample_ok = 1'b0;
		end
	end

	// decision sampled each phase one, taken at the end of the cycle;
	// instruction length is never looked at, so latency stays fixed
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sample_ff <= 1'b0;
		end else if (q1) begin
			sample_ff <= sample_ok;
		end else if (q4) begin
			sample_ff <= 1'b0;
		end
	end

	// gie re-checked so a software disable mid-cycle still blocks entry
	always_comb begin
		entry = 1'b0;
		if (q4 && sample_ff) begin
			entry = ctl_ff[CTL_GIE] & ~core_i.asleep;
		end
	end

	// one-cycle command strobe to the fetch sequencer
	always_comb begin
		nxt_cmd = '0;
		if (entry) begin
			nxt_cmd.flush       = 1'b1;
			nxt_cmd.push        = 1'b1;
			nxt_cmd.load_vector = 1'b1;
			nxt_cmd.vector      = VECTOR_ADDR;
		end
		if (core_i.return_from_interrupt) begin
			nxt_cmd.pop = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_ff <= '0;
		end else begin
			cmd_ff <= nxt_cmd;
		end
	end

	// in-service marker; a pending flag after return re-enters
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			in_service_ff <= 1'b0;
		end else if (entry) begin
			in_service_ff <= 1'b1;
		end else if (core_i.return_from_interrupt) begin
			in_service_ff <= 1'b0;
		end
	end

	assign regs_o.ctl       = ctl_ff;
	assign regs_o.pie       = pie_ff;
	assign regs_o.pir       = pir_ff;
	assign cmd_o            = cmd_ff;
	assign phase_o          = phase_ff;
	assign irq_req_o        = irq_req;
	assign service_active_o = in_service_ff;

endmodule : cis_core
`default_nettype wire

// [tb/cis_core_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module cis_core_asserts (
	input  wire logic                clk_i,
	input  wire logic                nrst_i,
	input  wire cis_pkg::cis_wr_s    wr_i,
	input  wire cis_pkg::cis_evt_s   events_i,
	input  wire cis_pkg::cis_core_s  core_i,
	input  wire cis_pkg::cis_regs_s  regs_o,
	input  wire cis_pkg::cis_cmd_s   cmd_o,
	input  wire cis_pkg::cis_phase_e phase_o,
	input  wire logic                irq_req_o
);
	import cis_pkg::*;
	logic [7:0] c;
	assign c = regs_o.ctl;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	chk_reset_clear: assert property (
		$rose(nrst_i) |-> regs_o == '0) else $error("state not clear");
	chk_req_form: assert property (
		irq_req_o == (c[7] & ((|(c[5:3] & c[2:0]))
		| (c[6] & (|(regs_o.pie & regs_o.pir))))))
		else $error("request gating wrong");
	chk_flag_set: assert property (
		events_i.timer_ovf |=> c[2]) else $error("timer flag not set");
	chk_entry_cmd: assert property (
		$rose(cmd_o.push) |-> cmd_o.flush && cmd_o.load_vector
		&& cmd_o.vector == VECTOR_ADDR && !c[7] && $past(c[7]))
		else $error("entry command wrong");
	chk_entry_pulse: assert property (
		cmd_o.push |=> !cmd_o.push) else $error("entry pulse too long");
	chk_return_gie: assert property (
		core_i.return_from_interrupt |=> c[7] && cmd_o.pop) else $error("return wrong");
	chk_pop_cause: assert property (
		cmd_o.pop |-> $past(core_i.return_from_interrupt)) else $error("stray pop");
	chk_entry_wait: assert property (
		irq_req_o && phase_o == PH_Q1 && !core_i.asleep
		|-> ##[1:20] cmd_o.push) else $error("entry too late");
	chk_ext_phase: assert property (
		$rose(c[1]) && !$past(wr_i.ctl_we)
		|-> $past(phase_o) inside {PH_Q4, PH_Q1})
		else $error("pin flag set in wrong phase");
endmodule : cis_core_asserts
bind cis_core cis_core_asserts u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
	.wr_i(wr_i), .events_i(events_i), .core_i(core_i), .regs_o(regs_o),
	.cmd_o(cmd_o), .phase_o(phase_o), .irq_req_o(irq_req_o));
`default_nettype wire

// [tb/cis_fetch_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cis_fetch_model #(
	parameter int DLY = 10
) (
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	input  wire cis_pkg::cis_cmd_s cmd_i,
	input  wire logic              sleep_i,
	input  wire logic              wake_i,
	output cis_pkg::cis_core_s     core_o
);
	import cis_pkg::*;
	logic asleep_ff;
	logic ret_ff;
	int   cnt_ff;
	assign core_o = '{ret_ff, asleep_ff};
	// sleep ends only on a wake reported by the device
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			asleep_ff <= 1'b0;
		else if (sleep_i)
			asleep_ff <= 1'b1;
		else if (wake_i)
			asleep_ff <= 1'b0;
	end
	// fixed routine length; only the pc was stacked, flags cleared by bench
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_ff <= 0;
			ret_ff <= 1'b0;
		end else begin
			ret_ff <= (cnt_ff == 1);
			if (cmd_i.push)
				cnt_ff <= DLY;
			else if (cnt_ff > 0)
				cnt_ff <= cnt_ff - 1;
		end
	end
endmodule : cis_fetch_model
`default_nettype wire

// [tb/core_interrupt_sequencer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module core_interrupt_sequencer_bench;
	import cis_pkg::*;
	logic       clk_i = 0, nrst_i = 0, pin = 0, esel = 0, go_sleep = 0;
	cis_wr_s    wr_i = '0;
	cis_evt_s   ev = '0;
	logic [3:0] pcf = '0;
	cis_core_s  core;
	cis_regs_s  regs;
	cis_cmd_s   cmd;
	cis_phase_e ph;
	logic       req, wake, svc;
	int         n_fail = 0, checked = 0, cyc = 0, n;
	logic [7:0] r;
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
	cis_core dut (.clk_i(clk_i), .nrst_i(nrst_i), .wr_i(wr_i),
		.events_i(ev), .ext_pin_i(pin), .ext_edge_select_i(esel),
		.pin_change_flag_reg_i(pcf), .core_i(core), .regs_o(regs),
		.cmd_o(cmd), .phase_o(ph), .irq_req_o(req), .wake_o(wake),
		.service_active_o(svc));
	cis_fetch_model model (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_i(cmd),
		.sleep_i(go_sleep), .wake_i(wake), .core_o(core));
	always #5 clk_i = ~clk_i;
	function automatic int lim(input int instruction_cycle_time);
		return instruction_cycle_time * PHASES_PER_CYCLE;
	endfunction : lim
	task close_out();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			close_out();
		end
	end
	task tk(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : tk
	task wr(input logic [2:0] k, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= {k, d};
		@(posedge clk_i);
		wr_i <= '0;
		#1;
	endtask : wr
	task ev_pulse(input logic t, input logic [7:0] p);
		@(posedge clk_i);
		ev <= '{t, p};
		@(posedge clk_i);
		ev <= '0;
		#1;
	endtask : ev_pulse
	// entry then routine: flags cleared before the model returns
	task serve(input string nm, input int lo, input int hi);
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (cmd.push !== 1'b1 && n < hi);
		`CHK(nm, 1'b1, n >= lo && n <= hi && cmd.push)
		`CHK("vector", 16'h0004, cmd.vector)
		`CHK("gie_off", 1'b0, regs.ctl[CTL_GIE])
		wr(3'b100, 8'h78);
		wr(3'b001, 8'h00);
		tk(12);
		`CHK("gie_back", 1'b1, regs.ctl[CTL_GIE])
		`CHK("svc_end", 1'b0, svc)
		$display("done %s", nm);
	endtask : serve
	initial begin
		void'($urandom(88894));
		tk(16);
		nrst_i <= 1'b1;
		tk(1);
		`CHK("reset", 24'h0, regs)
		r = 8'($urandom) | 8'h02;
		ev_pulse(1'b1, r);
		`CHK("pir", r & PERIPH_MASK, regs.pir)
		`CHK("tmr_f", 1'b1, regs.ctl[CTL_TMR_F])
		wr(3'b010, 8'hff);
		`CHK("pie", PERIPH_MASK, regs.pie)
		wr(3'b100, 8'h80);
		tk(8);
		`CHK("peripheral_irq_enable_gate", 1'b0, req | svc)
		wr(3'b100, 8'hc0);
		serve("periph", 1, lim(SYNC_LAT_MAX));
		wr(3'b100, 8'h20);
		ev_pulse(1'b1, 8'h00);
		tk(12);
		`CHK("held", 1'b0, svc)
		`CHK("kept", 1'b1, regs.ctl[CTL_TMR_F])
		wr(3'b100, 8'ha4);
		serve("late", 1, lim(SYNC_LAT_MAX));
		wr(3'b100, 8'h10);
		for (int s = 0; s < 2; s++) begin
			@(posedge clk_i);
			esel <= s[0];
			pin <= s[0];
			tk(10);
			wr(3'b100, 8'h10);
			@(posedge clk_i);
			pin <= ~s[0];
			tk(10);
			`CHK("wrong_edge", 1'b0, regs.ctl[CTL_EXT_F])
			@(posedge clk_i);
			pin <= s[0];
			tk(10);
			`CHK("right_edge", 1'b1, regs.ctl[CTL_EXT_F])
		end
		wr(3'b100, 8'h92);
		serve("pin", 1, lim(SYNC_LAT_MAX));
		for (int g = 0; g < 2; g++) begin
			wr(3'b100, g ? 8'ha0 : 8'h20);
			@(posedge clk_i);
			go_sleep <= 1'b1;
			@(posedge clk_i);
			go_sleep <= 1'b0;
			ev_pulse(1'b1, 8'h00);
			`CHK("wake", 1'b1, wake)
			if (g)
				serve("wake", lim(1), lim(ASYNC_LAT_MAX + 2));
			else begin
				tk(20);
				`CHK("no_gie_wake", 2'b00, {svc, core.asleep})
			end
		end
		wr(3'b100, 8'h00);
		@(posedge clk_i);
		pcf <= 4'($urandom) | 4'h1;
		tk(2);
		`CHK("summary", 1'b1, regs.ctl[CTL_PC_F])
		@(posedge clk_i);
		pcf <= '0;
		wr(3'b100, 8'h01);
		`CHK("summary_ro", 8'h00, regs.ctl)
		close_out();
	end
endmodule : core_interrupt_sequencer_bench
`default_nettype wire
